// >>> src/rcc_pkg.sv
package rcc_pkg;

	// clock and timing
	localparam int CLK_NS          = 8;
	localparam int CLAMP_LONG_NS   = 3400;
	localparam int CLAMP_SHORT_NS  = 1700;
	localparam int IDLE_RECOVER_NS = 15000;
	localparam int PRE_GAP_NS      = 400;
	localparam int CLAMP_LONG_CYC  = (CLAMP_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLAMP_SHORT_CYC = (CLAMP_SHORT_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDLE_RECOVER_CYC = IDLE_RECOVER_NS / CLK_NS;
	localparam int PRE_GAP_CYC     = PRE_GAP_NS / CLK_NS;
	localparam int PRE_PULSES      = 16;
	localparam int TMR_W           = 11;
	localparam int PCNT_W          = 5;

	// serial word: two bank address bits first, then thirteen data bits
	localparam int BANK_W      = 13;
	localparam int WORD_W      = 15;
	localparam int ADDR_MSB    = 14;
	localparam int ADDR_LSB    = 13;
	localparam int NUM_BANKS   = 4;

	localparam logic [1:0] BANK_00 = 2'h0;
	localparam logic [1:0] BANK_01 = 2'h1;
	localparam logic [1:0] BANK_10 = 2'h2;
	localparam logic [1:0] BANK_11 = 2'h3;

	localparam logic [BANK_W-1:0] BANK_00_RST = 13'h0000;
	localparam logic [BANK_W-1:0] BANK_01_RST = 13'h0000;
	localparam logic [BANK_W-1:0] BANK_10_RST = 13'h0000;
	localparam logic [BANK_W-1:0] BANK_11_RST = 13'h0000;

	// bank 00 fields
	localparam int DATA_EQ_LSB      = 9;
	localparam int SERVO_EQ_EN_BIT  = 12;
	// bank 10 fields
	localparam int REF_OUT_A_REF_EN_BIT = 5;
	localparam int PUMP_RATIO_BIT   = 12;
	// bank 11 fields
	localparam int ROUTE0_BIT       = 2;
	localparam int ROUTE1_BIT       = 3;
	localparam int PREAMBLE_SEL_BIT = 4;
	localparam int WG_INVERT_BIT    = 5;
	localparam int SLOW_BIT         = 6;
	localparam int SERVO_EQ_LSB     = 10;
	localparam int EQ_W             = 3;

	// avalon register map (byte addresses)
	localparam int AV_AW = 5;
	localparam logic [AV_AW-1:0] REG_STATUS = 5'h00;
	localparam logic [AV_AW-1:0] REG_CTRL   = 5'h04;
	localparam logic [AV_AW-1:0] REG_BANK0  = 5'h10;
	localparam logic [AV_AW-1:0] REG_BANK1  = 5'h14;
	localparam logic [AV_AW-1:0] REG_BANK2  = 5'h18;
	localparam logic [AV_AW-1:0] REG_BANK3  = 5'h1c;
	localparam logic CTRL_RST = 1'h0;

	typedef enum logic [0:0] {
		MUX_RUN  = 1'b0,
		MUX_PARK = 1'b1
	} rcc_mux_e;

endpackage

// >>> src/rcc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // rcc_sync2
`default_nettype wire

// >>> src/rcc_top.sv
// Functional notes
// [RULE1] write gate polarity set by invert bit
// [RULE2] write gate clamps inputs, freezes gain
// [RULE3] clamp stays 3.4us or 1.7us after
// [RULE4] idle powers detector down except bias
// [RULE5] idle keeps banks, blocks serial loading
// [RULE6] sleep resets all banks to defaults
// [RULE7] latch/shift low shifts data each rising edge
// [RULE8] latch rising edge loads addressed bank
// [RULE9] serial clock rising edge samples data
// [RULE10] controller keeps sleep/idle released while shifting
// [RULE11] frequency lock forced while read gate low
// [RULE12] read gate rise with lock enabled locks
// [RULE13] lock control high switches to tracking
// [RULE14] preamble found after sixteen pulses, latched
// [RULE15] controller raises read gate to read
// [RULE16] raw pulse output enabled else high
// [RULE17] external input replaces internal synchronizer feed
// [RULE18] both routing bits: fixed gain test
// [RULE19] glitch-free read/non-read clock multiplexer
// [RULE20] reference output high until enabled
// [RULE21] serial output allows daisy chaining
// [RULE22] servo field selects equalization group
// [RULE23] hold freezes gain, coasts in read
// [RULE24] serial output is last stage bit
// [RULE25] chosen decode for other routing codes
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rcc_top
	import rcc_pkg::*;
(
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic [AV_AW-1:0] avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             write_gate,
	input  wire logic             idle_servo,
	input  wire logic             sleep_n,
	input  wire logic             cfg_latch_shift,
	input  wire logic             cfg_serial_in,
	input  wire logic             cfg_clk,
	input  wire logic             freq_lock_ctrl_n,
	input  wire logic             read_gate,
	input  wire logic             det_pulse_in,
	input  wire logic             ext_pulse_in,
	input  wire logic             zps_done,
	input  wire logic             servo_field_select,
	input  wire logic             agc_hold_in,
	input  wire logic             synch_clk_in,
	input  wire logic             ref_out_a_clk_in,
	output logic                  cfg_serial_out,
	output logic                  amp_low_z,
	output logic                  agc_freeze,
	output logic                  pd_power_on,
	output logic                  pd_bias_on,
	output logic                  pd_ready,
	output logic                  core_power_on,
	output logic                  freq_lock,
	output logic                  phase_track,
	output logic                  preamble_3t,
	output logic                  preamble_found,
	output logic                  raw_pulse_out,
	output logic                  synch_pulse,
	output logic                  fixed_gain,
	output logic                  test_osc_en,
	output logic                  coast,
	output logic      [EQ_W-1:0]  eq_sel,
	output logic                  pump_gain_ratio,
	output logic                  mux_clk_out,
	output logic                  ref_out_a
);
	localparam int NSYNC = 15;

	logic [NSYNC-1:0] sync_v;
	logic wg_s, idle_s, sleep_n_s, ls_s, sdi_s, cclk_s, flc_n_s, rg_s;
	logic det_s, ext_s, zps_s, servo_field_select_s, hold_s, syc_s, sth_s;

	rcc_sync2 #(.W(NSYNC)) u_sync (
		.clock    (clock),
		.arst_n   (arst_n),
		.async_in ({write_gate, idle_servo, sleep_n, cfg_latch_shift,
		            cfg_serial_in, cfg_clk, freq_lock_ctrl_n, read_gate,
		            det_pulse_in, ext_pulse_in, zps_done,
		            servo_field_select, agc_hold_in, synch_clk_in,
		            ref_out_a_clk_in}),
		.sync_out (sync_v)
	);

	assign {wg_s, idle_s, sleep_n_s, ls_s, sdi_s, cclk_s, flc_n_s, rg_s,
	        det_s, ext_s, zps_s, servo_field_select_s, hold_s, syc_s, sth_s} = sync_v;

	// edge detectors look only at synchronised copies
	logic cclk_d_q, ls_d_q, rg_d_q, det_d_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cclk_d_q <= 1'b0;
			ls_d_q   <= 1'b1;
			rg_d_q   <= 1'b0;
			det_d_q  <= 1'b0;
		end else begin
			cclk_d_q <= cclk_s;
			ls_d_q   <= ls_s;
			rg_d_q   <= rg_s;
			det_d_q  <= det_s;
		end
	end

	logic cclk_rise, ls_rise, rg_rise, det_rise, load_ok;
	assign cclk_rise = cclk_s & ~cclk_d_q; // [RULE9]
	assign ls_rise   = ls_s & ~ls_d_q;
	assign rg_rise   = rg_s & ~rg_d_q;
	assign det_rise  = det_s & ~det_d_q;
	// input buffers are dead while idle or asleep
	assign load_ok   = sleep_n_s & ~idle_s; // [RULE5]

	// ---------------- serial configuration port ----------------
	logic [WORD_W-1:0] shift_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			shift_q        <= '0;
			cfg_serial_out <= 1'b0;
		end else if (!sleep_n_s) begin
			shift_q        <= '0; // [RULE6]
			cfg_serial_out <= 1'b0;
		end else if (load_ok && !ls_s && cclk_rise) begin
			shift_q        <= {shift_q[WORD_W-2:0], sdi_s}; // [RULE7]
			// the bit now standing in the last stage, ready for the next device
			cfg_serial_out <= shift_q[WORD_W-2]; // [RULE21] [RULE24]
		end
	end

	logic [BANK_W-1:0] bank_q [NUM_BANKS];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bank_q[0] <= BANK_00_RST;
			bank_q[1] <= BANK_01_RST;
			bank_q[2] <= BANK_10_RST;
			bank_q[3] <= BANK_11_RST;
		end else if (!sleep_n_s) begin
			bank_q[0] <= BANK_00_RST; // [RULE6]
			bank_q[1] <= BANK_01_RST;
			bank_q[2] <= BANK_10_RST;
			bank_q[3] <= BANK_11_RST;
		end else if (load_ok && ls_rise) begin
			bank_q[shift_q[ADDR_MSB:ADDR_LSB]] <= shift_q[BANK_W-1:0]; // [RULE8]
		end
	end

	logic route0, route1, pattern_3t, wg_inv, slow_rec, servo_eq_en;
	assign route0      = bank_q[BANK_11][ROUTE0_BIT];
	assign route1      = bank_q[BANK_11][ROUTE1_BIT];
	assign pattern_3t  = bank_q[BANK_11][PREAMBLE_SEL_BIT];
	assign wg_inv      = bank_q[BANK_11][WG_INVERT_BIT];
	assign slow_rec    = bank_q[BANK_11][SLOW_BIT];
	assign servo_eq_en = bank_q[BANK_00][SERVO_EQ_EN_BIT];

	// ---------------- write gate clamp ----------------
	logic wg_act;
	logic [TMR_W-1:0] clamp_q;
	assign wg_act = wg_s ^ wg_inv; // [RULE1]

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clamp_q   <= '0;
			amp_low_z <= 1'b0;
		end else if (wg_act) begin
			// reload so the release delay starts when the gate drops
			clamp_q   <= slow_rec ? TMR_W'(CLAMP_SHORT_CYC - 1)
			                      : TMR_W'(CLAMP_LONG_CYC - 1); // [RULE3]
			amp_low_z <= 1'b1; // [RULE2]
		end else if (clamp_q != '0) begin
			clamp_q   <= clamp_q - 1'b1; // [RULE3]
			amp_low_z <= 1'b1;
		end else begin
			amp_low_z <= 1'b0;
		end
	end

	// ---------------- power states ----------------
	logic [TMR_W-1:0] wake_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pd_power_on   <= 1'b0;
			pd_bias_on    <= 1'b0;
			core_power_on <= 1'b0;
			pd_ready      <= 1'b0;
			wake_q        <= '0;
		end else begin
			pd_power_on   <= sleep_n_s & ~idle_s; // [RULE4]
			pd_bias_on    <= sleep_n_s; // [RULE4]
			// synchroniser and synthesiser ignore idle
			core_power_on <= sleep_n_s; // [RULE4] [RULE6]
			if (!sleep_n_s || idle_s) begin
				wake_q   <= TMR_W'(IDLE_RECOVER_CYC - 1);
				pd_ready <= 1'b0;
			end else if (wake_q != '0) begin
				wake_q   <= wake_q - 1'b1; // [RULE4]
			end else begin
				pd_ready <= 1'b1;
			end
		end
	end

	// ---------------- frequency lock sequencing ----------------
	logic lock_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lock_q      <= 1'b1;
			freq_lock   <= 1'b1;
			phase_track <= 1'b0;
			preamble_3t <= 1'b0;
		end else begin
			if (!rg_s)
				lock_q <= 1'b1; // [RULE11]
			else if (rg_rise)
				lock_q <= ~flc_n_s; // [RULE12]
			else if (flc_n_s)
				lock_q <= 1'b0; // [RULE13]
			// lock control has no effect while read gate is low
			freq_lock   <= ~rg_s | (rg_rise ? ~flc_n_s : lock_q & ~flc_n_s); // [RULE11] [RULE15]
			phase_track <= rg_s & ~(rg_rise ? ~flc_n_s : lock_q & ~flc_n_s); // [RULE13]
			preamble_3t <= pattern_3t; // [RULE12]
		end
	end

	// ---------------- preamble detect ----------------
	logic [PCNT_W-1:0] pcnt_q;
	logic [7:0]        gap_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pcnt_q         <= '0;
			gap_q          <= '0;
			preamble_found <= 1'b0;
		end else if (!rg_s) begin
			pcnt_q         <= '0; // [RULE14]
			gap_q          <= '0;
			preamble_found <= 1'b0;
		end else if (!preamble_found && zps_s) begin
			if (det_rise) begin
				gap_q <= '0;
				// a long gap breaks the run of preamble pulses
				if (pcnt_q != '0 && gap_q > 8'(PRE_GAP_CYC))
					pcnt_q <= PCNT_W'(1);
				else
					pcnt_q <= pcnt_q + 1'b1;
				if (pcnt_q == PCNT_W'(PRE_PULSES - 1) &&
				    gap_q <= 8'(PRE_GAP_CYC))
					preamble_found <= 1'b1; // [RULE14]
			end else if (gap_q != 8'hff) begin
				gap_q <= gap_q + 1'b1;
			end
		end
	end

	// ---------------- pulse routing ----------------
	logic out_en, ext_en, test_mode, ctrl_q;

	always_comb begin
		// 00 normal, 01 raw out, 10 external in, 11 test
		out_en    = route0; // [RULE25]
		ext_en    = route1; // [RULE25]
		test_mode = route0 & route1; // [RULE18]
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			raw_pulse_out <= 1'b1;
			synch_pulse   <= 1'b0;
			fixed_gain    <= 1'b0;
			test_osc_en   <= 1'b0;
		end else begin
			raw_pulse_out <= out_en ? det_s : 1'b1; // [RULE16]
			synch_pulse   <= ext_en ? ext_s : det_s; // [RULE17]
			fixed_gain    <= test_mode; // [RULE18]
			test_osc_en   <= test_mode & ctrl_q; // [RULE18]
		end
	end

	// ---------------- gain hold, equalisation, pump ----------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			agc_freeze      <= 1'b0;
			coast           <= 1'b0;
			eq_sel          <= '0;
			pump_gain_ratio <= 1'b0;
		end else begin
			agc_freeze <= hold_s | wg_act | test_mode; // [RULE2] [RULE23]
			coast      <= hold_s & rg_s; // [RULE23]
			if (servo_eq_en && servo_field_select_s)
				eq_sel <= bank_q[BANK_11][SERVO_EQ_LSB +: EQ_W]; // [RULE22]
			else
				eq_sel <= bank_q[BANK_00][DATA_EQ_LSB +: EQ_W]; // [RULE22]
			pump_gain_ratio <= bank_q[BANK_10][PUMP_RATIO_BIT];
		end
	end

	// ---------------- clock outputs ----------------
	rcc_mux_e mux_st_q;
	logic     mux_sel_q;
	logic     cur_clk, new_clk;
	assign cur_clk = mux_sel_q ? syc_s : sth_s;
	assign new_clk = rg_s ? syc_s : sth_s;

	// park low once the current source is low, switch once the new source is low, so no runt pulse escapes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mux_st_q    <= MUX_RUN;
			mux_sel_q   <= 1'b0;
			mux_clk_out <= 1'b0;
		end else begin
			case (mux_st_q)
				MUX_RUN: begin
					if (rg_s != mux_sel_q && !cur_clk) begin
						mux_st_q    <= MUX_PARK; // [RULE19]
						mux_clk_out <= 1'b0;
					end else begin
						mux_clk_out <= cur_clk;
					end
				end
				MUX_PARK: begin
					mux_clk_out <= 1'b0;
					if (!new_clk) begin
						mux_sel_q <= rg_s; // [RULE19]
						mux_st_q  <= MUX_RUN;
					end
				end
				default: begin
					mux_st_q    <= MUX_RUN;
					mux_clk_out <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			ref_out_a <= 1'b1;
		else
			ref_out_a <= bank_q[BANK_10][REF_OUT_A_REF_EN_BIT] ? sth_s : 1'b1; // [RULE20]
	end

	// ---------------- avalon slave, one wait state ----------------
	logic av_req;
	assign av_req = avs_read | avs_write;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
			ctrl_q          <= CTRL_RST;
		end else begin
			avs_waitrequest <= ~(av_req & avs_waitrequest);
			if (av_req && avs_waitrequest) begin
				case (avs_address)
					REG_STATUS: avs_readdata <= {26'h0, ~sleep_n_s, pd_ready,
					                             test_mode, idle_s,
					                             freq_lock, preamble_found};
					REG_CTRL:   avs_readdata <= {31'h0, ctrl_q};
					REG_BANK0:  avs_readdata <= {19'h0, bank_q[0]};
					REG_BANK1:  avs_readdata <= {19'h0, bank_q[1]};
					REG_BANK2:  avs_readdata <= {19'h0, bank_q[2]};
					REG_BANK3:  avs_readdata <= {19'h0, bank_q[3]};
					default:    avs_readdata <= 32'h0;
				endcase
				if (avs_write && avs_address == REG_CTRL)
					ctrl_q <= avs_writedata[0];
			end
		end
	end

endmodule // rcc_top
`default_nettype wire

// >>> testbench/rcc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_top_asserts (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic avs_waitrequest,
	input wire logic read_gate,
	input wire logic idle_servo,
	input wire logic sleep_n,
	input wire logic agc_hold_in,
	input wire logic freq_lock,
	input wire logic phase_track,
	input wire logic preamble_found,
	input wire logic pd_power_on,
	input wire logic pd_bias_on,
	input wire logic core_power_on,
	input wire logic coast,
	input wire logic agc_freeze,
	input wire logic amp_low_z,
	input wire logic fixed_gain,
	input wire logic mux_clk_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	// four samples cover the two-flop pin synchroniser plus the output flop
	sequence s_rg_low;
		(!read_gate)[*4];
	endsequence
	sequence s_idle;
		(idle_servo && sleep_n)[*4];
	endsequence
	sequence s_hold_rd;
		(agc_hold_in && read_gate)[*4];
	endsequence

	chk_lock_rg_low: assert property (s_rg_low |-> freq_lock)
		else $error("lock dropped with read gate low");
	chk_pream_clear: assert property (s_rg_low |-> !preamble_found)
		else $error("preamble flag high with read gate low");
	chk_track_excl: assert property (!(freq_lock && phase_track))
		else $error("lock and tracking together");
	chk_idle_power: assert property (s_idle |->
		!pd_power_on && pd_bias_on && core_power_on)
		else $error("idle power state wrong");
	chk_sleep_down: assert property ((!sleep_n)[*4] |->
		!core_power_on && !pd_bias_on)
		else $error("sleep left power on");
	chk_hold_coast: assert property (s_hold_rd |-> coast && agc_freeze)
		else $error("hold in read did not coast");
	chk_clamp_min: assert property ($rose(amp_low_z) |=> amp_low_z[*8])
		else $error("clamp too short");
	chk_test_gain: assert property (fixed_gain |-> agc_freeze)
		else $error("fixed gain without frozen gain");
	chk_mux_glitch: assert property ($rose(mux_clk_out) |=> mux_clk_out)
		else $error("clock mux glitch");
	chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low two cycles");
endmodule // rcc_top_asserts

bind rcc_top rcc_top_asserts CHK (
	.clock, .arst_n, .avs_waitrequest, .read_gate, .idle_servo, .sleep_n,
	.agc_hold_in, .freq_lock, .phase_track, .preamble_found, .pd_power_on,
	.pd_bias_on, .core_power_on, .coast, .agc_freeze, .amp_low_z,
	.fixed_gain, .mux_clk_out
);
`default_nettype wire

// >>> testbench/rcc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_ctl_model (
	output logic cfg_latch_shift,
	output logic cfg_serial_in,
	output logic cfg_clk
);
	initial begin
		cfg_latch_shift = 1'h1;
		cfg_serial_in = 1'h0;
		cfg_clk = 1'h0;
	end

	// serial clock only runs inside a frame; data moves on its falling edge
	task automatic load(input logic [1:0] bank, input logic [12:0] data);
		logic [14:0] word;
		word = {bank, data};
		#3 cfg_latch_shift = 1'h0;
		for (int i = 14; i >= 0; i--) begin
			cfg_serial_in = word[i];
			#80 cfg_clk = 1'h1;
			#80 cfg_clk = 1'h0;
		end
		// released line flips so a stale bit cannot pass as good data
		cfg_serial_in = ~word[0];
		#80 cfg_latch_shift = 1'h1;
		#80;
	endtask
endmodule // rcc_ctl_model
`default_nettype wire

// >>> testbench/rcc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_top_bench
	import rcc_pkg::*;
;
	typedef struct {
		string       n;
		bit          rd;
		logic [31:0] m;
		logic [31:0] v;
	} rcc_note_s;
	logic             clock = 1'h0, arst_n = 1'h0, avs_read = 1'h0;
	logic             avs_write = 1'h0, write_gate = 1'h0, idle_servo = 1'h0;
	logic             sleep_n = 1'h1, zps_done = 1'h0, read_gate = 1'h0;
	logic             freq_lock_ctrl_n = 1'h0, det_pulse_in = 1'h0;
	logic             ext_pulse_in = 1'h1, servo_field_select = 1'h0;
	logic             agc_hold_in = 1'h0, synch_clk_in = 1'h0;
	logic             ref_out_a_clk_in = 1'h0;
	logic [AV_AW-1:0] avs_address = 5'h0;
	logic [31:0]      avs_writedata = 32'h0, avs_readdata, ov;
	logic             avs_waitrequest, cfg_latch_shift, cfg_serial_in, cfg_clk;
	logic             cfg_serial_out, amp_low_z, agc_freeze, pd_power_on;
	logic             pd_bias_on, pd_ready, core_power_on, freq_lock;
	logic             phase_track, preamble_3t, preamble_found, raw_pulse_out;
	logic             synch_pulse, fixed_gain, test_osc_en, coast;
	logic             pump_gain_ratio, mux_clk_out, ref_out_a;
	logic [EQ_W-1:0]  eq_sel;
	logic [31:0]      seed = 32'h086e;
	logic [7:0]       tick = 8'h0;
	logic [12:0]      bk [4];
	int               error_cnt = 0, checked = 0;
	rcc_note_s        nq [$];

	rcc_top DUT (
		.clock, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .write_gate, .idle_servo, .sleep_n,
		.cfg_latch_shift, .cfg_serial_in, .cfg_clk, .freq_lock_ctrl_n,
		.read_gate, .det_pulse_in, .ext_pulse_in, .zps_done,
		.servo_field_select, .agc_hold_in, .synch_clk_in, .ref_out_a_clk_in,
		.cfg_serial_out, .amp_low_z, .agc_freeze, .pd_power_on, .pd_bias_on,
		.pd_ready, .core_power_on, .freq_lock, .phase_track, .preamble_3t,
		.preamble_found, .raw_pulse_out, .synch_pulse, .fixed_gain,
		.test_osc_en, .coast, .eq_sel, .pump_gain_ratio, .mux_clk_out,
		.ref_out_a
	);
	rcc_ctl_model CTL (.cfg_latch_shift, .cfg_serial_in, .cfg_clk);

	// bit map of the level outputs watched by the monitor
	assign ov = {11'h0, eq_sel, cfg_serial_out, ref_out_a, pump_gain_ratio,
		coast, test_osc_en, fixed_gain, synch_pulse, raw_pulse_out,
		preamble_found, preamble_3t, phase_track, freq_lock, core_power_on,
		pd_ready, pd_bias_on, pd_power_on, agc_freeze, amp_low_z};

	initial begin
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		tick <= tick + 8'h1;
		synch_clk_in <= tick[2];
		ref_out_a_clk_in <= tick[4];
	end
	always @(negedge clock) begin
		while (nq.size() > 0) begin
			rcc_note_s   t;
			logic [31:0] s;
			t = nq.pop_front();
			s = (t.rd ? avs_readdata : ov) & t.m;
			checked++;
			if (s !== t.v) begin
				error_cnt++;
				$display("wrong value %s exp %h got %h", t.n, t.v, s);
			end
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic note(string n, bit rd, logic [31:0] m, logic [31:0] v);
		nq.push_back('{n, rd, m, v & m});
	endtask
	task automatic bt(input string n, input int b, input logic e);
		note(n, 1'h0, 32'h1 << b, {31'h0, e} << b);
	endtask
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (n >= 50) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		av(1'h0, a, 32'h0);
		note("readdata", 1'h1, 32'hffffffff, e);
	endtask
	task automatic ld(input logic [1:0] a, input logic [12:0] d, input logic ok);
		CTL.load(a, d);
		cyc(6);
		if (ok)
			bk[a] = d;
		if (ok)
			bt("serial_out", 17, a[1]);
		rd(REG_BANK0 | {1'h0, a, 2'h0}, {19'h0, bk[a]});
	endtask
	task automatic pulse();
		det_pulse_in <= 1'h1;
		cyc(2);
		det_pulse_in <= 1'h0;
		cyc(2);
	endtask
	// release is checked three cycles early and eleven cycles late to allow for synchronisers
	task automatic wg(input logic inv, input logic slow, input int n);
		write_gate <= inv;
		ld(2'h3, {6'h0, slow, inv, 5'h0}, 1'h1);
		write_gate <= !inv;
		cyc(5);
		bt("low_z", 0, 1'h1);
		bt("agc_freeze", 1, 1'h1);
		write_gate <= inv;
		cyc(n - 1);
		bt("low_z", 0, 1'h1);
		cyc(14);
		bt("low_z", 0, 1'h0);
	endtask
	task automatic report_and_stop();
		cyc(2);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#500000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		cyc(12);
		arst_n <= 1'h1;
		cyc(1);
		bt("ref_out", 16, 1'h1);
		bt("raw_out", 10, 1'h1);
		bt("freq_lock", 6, 1'h1);
		rd(REG_CTRL, 32'h0);
		rd(5'h08, 32'h0);
		av(1'h1, REG_CTRL, 32'h1);
		rd(REG_CTRL, 32'h1);
		av(1'h1, REG_BANK1, 32'h1fff);
		rd(REG_BANK1, 32'h0);
		for (int i = 0; i < 4; i++)
			ld(2'(i), 13'(rnd()) & 13'h1fdf, 1'h1);
		bt("pump_ratio", 15, bk[2][12]);
		bt("ref_out", 16, 1'h1);
		bt("pream_3t", 8, bk[3][4]);
		ld(2'h0, 13'h1000 | (13'(rnd()) & 13'h0e00), 1'h1);
		for (int r = 0; r < 4; r++) begin
			ld(2'h3, {3'(r), 6'h0, 2'(r), 2'h0}, 1'h1);
			bt("raw_out", 10, !r[0]);
			bt("synch_pulse", 11, r[1]);
			bt("fixed_gain", 12, r == 3);
			bt("test_osc", 13, r == 3);
			note("eq_sel", 1'h0, 32'h1c0000, {11'h0, bk[0][11:9], 18'h0});
			servo_field_select <= 1'h1;
			cyc(5);
			note("eq_sel", 1'h0, 32'h1c0000, {11'h0, 3'(r), 18'h0});
			servo_field_select <= 1'h0;
		end
		ld(2'h3, 13'h0010, 1'h1);
		freq_lock_ctrl_n <= 1'h1;
		cyc(5);
		bt("freq_lock", 6, 1'h1);
		freq_lock_ctrl_n <= 1'h0;
		read_gate <= 1'h1;
		zps_done <= 1'h1;
		cyc(5);
		bt("freq_lock", 6, 1'h1);
		bt("pream_3t", 8, 1'h1);
		repeat (15) pulse();
		bt("pream_found", 9, 1'h0);
		pulse();
		cyc(4);
		bt("pream_found", 9, 1'h1);
		freq_lock_ctrl_n <= 1'h1;
		agc_hold_in <= 1'h1;
		cyc(5);
		bt("freq_lock", 6, 1'h0);
		bt("track", 7, 1'h1);
		bt("coast", 14, 1'h1);
		read_gate <= 1'h0;
		cyc(5);
		bt("coast", 14, 1'h0);
		bt("pream_found", 9, 1'h0);
		agc_hold_in <= 1'h0;
		idle_servo <= 1'h1;
		cyc(5);
		bt("pd_ready", 4, 1'h0);
		ld(2'h3, 13'h0aaa, 1'h0);
		idle_servo <= 1'h0;
		cyc(IDLE_RECOVER_CYC - 8);
		bt("pd_ready", 4, 1'h0);
		cyc(16);
		bt("pd_ready", 4, 1'h1);
		wg(1'h0, 1'h0, CLAMP_LONG_CYC);
		wg(1'h0, 1'h1, CLAMP_SHORT_CYC);
		wg(1'h1, 1'h0, CLAMP_LONG_CYC);
		sleep_n <= 1'h0;
		cyc(5);
		sleep_n <= 1'h1;
		cyc(5);
		bt("pream_3t", 8, 1'h0);
		bt("serial_out", 17, 1'h0);
		for (int i = 0; i < 4; i++)
			rd(REG_BANK0 | {1'h0, 2'(i), 2'h0}, 32'h0);
		report_and_stop();
	end
endmodule // rcc_top_bench
`default_nettype wire
